// file: hw/alarm_warning_pkg.sv
// Constants, register map and bit layout of the alarm and warning status words
package alarm_warning_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int WORD_W = 32;
	localparam int ADDR_W = 8;
	localparam int IRQ_W = 3;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_ALARM_ONE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ALARM_TWO = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_WARN_ONE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_WARN_TWO = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1C;

	// ----------------------------------------------------------------
	// Alarm word one condition bits
	// ----------------------------------------------------------------
	localparam logic [WORD_W-1:0] ALM1_BRAKE_CHECK = 32'h0000_0001;
	localparam logic [WORD_W-1:0] ALM1_EARTH_FAULT = 32'h0000_0004;
	localparam logic [WORD_W-1:0] ALM1_OVER_CURRENT = 32'h0000_0020;
	localparam logic [WORD_W-1:0] ALM1_PHASE_U_LOST = 32'h0008_0000;
	localparam logic [WORD_W-1:0] ALM1_PHASE_V_LOST = 32'h0010_0000;
	localparam logic [WORD_W-1:0] ALM1_PHASE_W_LOST = 32'h0020_0000;
	// Top bit is unused, all others carry a condition
	localparam logic [WORD_W-1:0] ALM1_VALID = 32'h7FFF_FFFF | ALM1_BRAKE_CHECK
		| ALM1_EARTH_FAULT | ALM1_OVER_CURRENT | ALM1_PHASE_U_LOST
		| ALM1_PHASE_V_LOST | ALM1_PHASE_W_LOST;

	// ----------------------------------------------------------------
	// Alarm word two condition bits
	// ----------------------------------------------------------------
	localparam logic [WORD_W-1:0] ALM2_SERVICE_RW = 32'h0000_0001;
	localparam logic [WORD_W-1:0] ALM2_FANS_ERROR = 32'h0004_0000;
	localparam logic [WORD_W-1:0] ALM2_BYPASS_OPTION = 32'h0008_0000;
	localparam logic [WORD_W-1:0] ALM2_VALID = 32'h0000_00F4 | ALM2_SERVICE_RW
		| ALM2_FANS_ERROR | ALM2_BYPASS_OPTION;

	// ----------------------------------------------------------------
	// Warning word bits
	// ----------------------------------------------------------------
	localparam logic [WORD_W-1:0] WRN1_BRAKE_RES_POWER = 32'h0004_0000;
	localparam logic [WORD_W-1:0] WRN1_VALID = 32'h3FFF_FFFF | WRN1_BRAKE_RES_POWER;
	localparam logic [WORD_W-1:0] WRN2_START_DELAYED = 32'h0000_0001;
	localparam logic [WORD_W-1:0] WRN2_STOP_DELAYED = 32'h0000_0002;
	localparam logic [WORD_W-1:0] WRN2_CLOCK_FAILURE = 32'h0000_0004;
	localparam logic [WORD_W-1:0] WRN2_VALID = 32'h000C_01E0 | WRN2_START_DELAYED
		| WRN2_STOP_DELAYED | WRN2_CLOCK_FAILURE;

	// ----------------------------------------------------------------
	// Control, status and interrupt fields
	// ----------------------------------------------------------------
	localparam int CTRL_ACK_BIT = 3;
	localparam int STS_FAULT_BIT = 3;
	localparam int STS_WARN_TOGGLE_BIT = 7;
	localparam int IRQ_ALARM_BIT = 0;
	localparam int IRQ_WARN_BIT = 1;
	localparam int IRQ_CLEARED_BIT = 2;
	localparam logic [WORD_W-1:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Drive state
	// ----------------------------------------------------------------
	typedef enum logic {
		st_run = 1'b0,
		st_fault = 1'b1
	} drive_state_type;

endpackage : alarm_warning_pkg

// file: hw/cond_sync.sv
// Two-stage synchroniser for the condition inputs
module cond_sync #(
	parameter int WIDTH = 128
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule : cond_sync

// file: hw/alarm_warning_status_words.sv
// Alarm and warning status words with fault state, APB slave and interrupt
//
// How it works
// - Any alarm forces fault, stops the drive
// - Fault ends on acknowledge with alarms gone
// - Warnings follow conditions, never cause fault
// - One bit per warning, one means active
// - One bit per alarm, one means present
// - Warning change toggles status word bit seven
// - Word value combines all active bits
// - Brake check, earth fault, over current positions
// - Missing motor phases U, V, W
// - Service trip, fans, bypass option positions
// - Brake resistor power limit warning position
// - Start delayed, stop delayed, clock failure
//
// Decided for this implementation: the APB register port and the address map.
module alarm_warning_status_words (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [alarm_warning_pkg::ADDR_W-1:0] paddr,
	input wire logic [alarm_warning_pkg::WORD_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [alarm_warning_pkg::WORD_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Raw condition inputs
	input wire logic [alarm_warning_pkg::WORD_W-1:0] alarm_cond_one,
	input wire logic [alarm_warning_pkg::WORD_W-1:0] alarm_cond_two,
	input wire logic [alarm_warning_pkg::WORD_W-1:0] warning_cond_one,
	input wire logic [alarm_warning_pkg::WORD_W-1:0] warning_cond_two,
	// Drive control
	output logic drive_run_enable,
	output logic fault_active,
	// Interrupt
	output logic irq
);

	localparam int W = alarm_warning_pkg::WORD_W;
	localparam int IW = alarm_warning_pkg::IRQ_W;

	// ----------------------------------------------------------------
	// Condition synchronisation
	// ----------------------------------------------------------------
	logic [4*W-1:0] cond_sync_out;
	logic [W-1:0] alarm_live_one;
	logic [W-1:0] alarm_live_two;
	logic [W-1:0] warn_live_one;
	logic [W-1:0] warn_live_two;
	logic alarm_live_any;
	cond_sync #(
		.WIDTH(4*W)
	) u_cond_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({alarm_cond_one, alarm_cond_two, warning_cond_one, warning_cond_two}),
		.sync_out(cond_sync_out)
	);

	// Unused and reserved positions are masked off
	always_comb
	begin
		alarm_live_one = cond_sync_out[4*W-1:3*W] & alarm_warning_pkg::ALM1_VALID;
		alarm_live_two = cond_sync_out[3*W-1:2*W] & alarm_warning_pkg::ALM2_VALID;
		warn_live_one = cond_sync_out[2*W-1:W] & alarm_warning_pkg::WRN1_VALID;
		warn_live_two = cond_sync_out[W-1:0] & alarm_warning_pkg::WRN2_VALID;
		alarm_live_any = |{alarm_live_one, alarm_live_two};
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic apb_setup;
	logic apb_wr;
	logic ctrl_wr;
	logic irq_sts_wr;
	logic irq_mask_wr;
	logic addr_hit;
	logic ack_pulse;
	logic [W-1:0] wr_bytes;
	// Writes take effect in the access cycle; address hit comes from the read mux
	always_comb
	begin
		apb_setup = psel && !penable;
		apb_wr = psel && penable && pwrite;
		ctrl_wr = apb_wr && (paddr == alarm_warning_pkg::OFS_CTRL);
		irq_sts_wr = apb_wr && (paddr == alarm_warning_pkg::OFS_IRQ_STS);
		irq_mask_wr = apb_wr && (paddr == alarm_warning_pkg::OFS_IRQ_MASK);
		wr_bytes = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	end

	// ----------------------------------------------------------------
	// Control word
	// ----------------------------------------------------------------
	logic [W-1:0] ctrl_r;
	logic [W-1:0] ctrl_nxt;
	// Acknowledge is the write that raises the ack bit, seen in its access cycle before it is stored
	always_comb
	begin
		ctrl_nxt = ctrl_wr ? ((ctrl_r & ~wr_bytes) | (pwdata & wr_bytes)) : ctrl_r;
		ack_pulse = ctrl_nxt[alarm_warning_pkg::CTRL_ACK_BIT]
			&& !ctrl_r[alarm_warning_pkg::CTRL_ACK_BIT];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= alarm_warning_pkg::CTRL_RESET;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Fault state and alarm words
	// ----------------------------------------------------------------
	alarm_warning_pkg::drive_state_type state_r;
	alarm_warning_pkg::drive_state_type state_nxt;
	logic [W-1:0] alarm_one_r;
	logic [W-1:0] alarm_one_nxt;
	logic [W-1:0] alarm_two_r;
	logic [W-1:0] alarm_two_nxt;
	logic fault_leave;
	// Alarms accumulate while in fault and clear on a valid acknowledge
	always_comb
	begin
		fault_leave = (state_r == alarm_warning_pkg::st_fault) && ack_pulse
			&& !alarm_live_any;
		state_nxt = state_r;
		unique case (state_r)
			alarm_warning_pkg::st_run:
				state_nxt = alarm_live_any ? alarm_warning_pkg::st_fault : state_r;
			alarm_warning_pkg::st_fault:
				state_nxt = fault_leave ? alarm_warning_pkg::st_run : state_r;
		endcase
		// No alarm is live when leaving, so the words fall to zero
		alarm_one_nxt = alarm_live_one
			| ((fault_active && !fault_leave) ? alarm_one_r : '0);
		alarm_two_nxt = alarm_live_two
			| ((fault_active && !fault_leave) ? alarm_two_r : '0);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= alarm_warning_pkg::st_run;
			alarm_one_r <= '0;
			alarm_two_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			alarm_one_r <= alarm_one_nxt;
			alarm_two_r <= alarm_two_nxt;
		end
	end

	assign fault_active = (state_r == alarm_warning_pkg::st_fault);
	assign drive_run_enable = (state_r == alarm_warning_pkg::st_run);

	// ----------------------------------------------------------------
	// Warning words and status toggle
	// ----------------------------------------------------------------
	logic [W-1:0] warn_one_r;
	logic [W-1:0] warn_two_r;
	logic warn_changed;
	logic warn_toggle_r;
	logic warn_toggle_nxt;
	// Warnings track their conditions; any change flips the toggle bit
	always_comb
	begin
		warn_changed = (warn_live_one != warn_one_r) || (warn_live_two != warn_two_r);
		warn_toggle_nxt = warn_toggle_r ^ warn_changed;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			warn_one_r <= '0;
			warn_two_r <= '0;
			warn_toggle_r <= 1'b0;
		end
		else
		begin
			warn_one_r <= warn_live_one;
			warn_two_r <= warn_live_two;
			warn_toggle_r <= warn_toggle_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	logic [IW-1:0] irq_sts_r;
	logic [IW-1:0] irq_sts_nxt;
	logic [IW-1:0] irq_mask_r;
	logic [IW-1:0] irq_mask_nxt;
	logic [IW-1:0] irq_set;
	logic [IW-1:0] irq_clr;
	// Set wins over a write-one-to-clear in the same cycle
	always_comb
	begin
		irq_set = '0;
		irq_set[alarm_warning_pkg::IRQ_ALARM_BIT] = (state_r == alarm_warning_pkg::st_run)
			&& alarm_live_any;
		irq_set[alarm_warning_pkg::IRQ_WARN_BIT] = warn_changed;
		irq_set[alarm_warning_pkg::IRQ_CLEARED_BIT] = fault_leave;
		irq_clr = (irq_sts_wr && pstrb[0]) ? pwdata[IW-1:0] : '0;
		irq_sts_nxt = (irq_sts_r & ~irq_clr) | irq_set;
		irq_mask_nxt = (irq_mask_wr && pstrb[0]) ? pwdata[IW-1:0] : irq_mask_r;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_sts_r <= alarm_warning_pkg::IRQ_RESET;
			irq_mask_r <= alarm_warning_pkg::IRQ_RESET;
		end
		else
		begin
			irq_sts_r <= irq_sts_nxt;
			irq_mask_r <= irq_mask_nxt;
		end
	end

	assign irq = |(irq_sts_r & irq_mask_r);

	// ----------------------------------------------------------------
	// Read data, captured in the setup cycle
	// ----------------------------------------------------------------
	logic [W-1:0] rd_mux;
	logic [W-1:0] status_word;
	logic [W-1:0] prdata_r;
	logic [W-1:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	always_comb
	begin
		status_word = '0;
		addr_hit = 1'b1;
		status_word[alarm_warning_pkg::STS_FAULT_BIT] = fault_active;
		status_word[alarm_warning_pkg::STS_WARN_TOGGLE_BIT] = warn_toggle_r;
		unique case (paddr)
			alarm_warning_pkg::OFS_ALARM_ONE: rd_mux = alarm_one_r;
			alarm_warning_pkg::OFS_ALARM_TWO: rd_mux = alarm_two_r;
			alarm_warning_pkg::OFS_WARN_ONE: rd_mux = warn_one_r;
			alarm_warning_pkg::OFS_WARN_TWO: rd_mux = warn_two_r;
			alarm_warning_pkg::OFS_CTRL: rd_mux = ctrl_r;
			alarm_warning_pkg::OFS_STATUS: rd_mux = status_word;
			alarm_warning_pkg::OFS_IRQ_STS: rd_mux = {{(W-IW){1'b0}}, irq_sts_r};
			alarm_warning_pkg::OFS_IRQ_MASK: rd_mux = {{(W-IW){1'b0}}, irq_mask_r};
			default:
			begin
				rd_mux = '0;
				addr_hit = 1'b0;
			end
		endcase
		prdata_nxt = apb_setup ? ((pwrite || !addr_hit) ? '0 : rd_mux) : prdata_r;
		pslverr_nxt = apb_setup ? !addr_hit : pslverr_r;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pslverr = pslverr_r && psel && penable;
	assign pready = 1'b1;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence seq_ack_clean;
		fault_active && ack_pulse && !alarm_live_any;
	endsequence
	sequence seq_back_to_run;
		drive_run_enable && (alarm_one_r == '0) && (alarm_two_r == '0);
	endsequence
	chk_fault_entry: assert property (drive_run_enable && alarm_live_any |=>
		fault_active && !drive_run_enable)
		else $error("alarm did not force fault");
	chk_fault_exit: assert property (seq_ack_clean |=> seq_back_to_run)
		else $error("clean acknowledge did not end fault");
	chk_fault_hold: assert property (fault_active && !(ack_pulse && !alarm_live_any)
		|=> fault_active)
		else $error("fault left without clean acknowledge");
	chk_warn_no_fault: assert property (drive_run_enable && !alarm_live_any
		|=> drive_run_enable)
		else $error("warning alone stopped the drive");
	chk_warn_follow: assert property (##1 (warn_one_r == $past(warn_live_one))
		&& (warn_two_r == $past(warn_live_two)))
		else $error("warning word not following condition");
	chk_warn_toggle: assert property (warn_changed |=>
		status_word[alarm_warning_pkg::STS_WARN_TOGGLE_BIT] != $past(warn_toggle_r))
		else $error("status toggle missed a warning change");
	chk_alarm_sticky: assert property (fault_active && !fault_leave |=>
		((alarm_one_r & $past(alarm_one_r)) == $past(alarm_one_r)))
		else $error("alarm bit dropped during fault");
	chk_alarm_combine: assert property (fault_active && !fault_leave |=>
		alarm_two_r == ($past(alarm_two_r) | $past(alarm_live_two)))
		else $error("alarm word does not combine active bits");
	chk_reserved_zero: assert property (((alarm_one_r & ~alarm_warning_pkg::ALM1_VALID)
		| (alarm_two_r & ~alarm_warning_pkg::ALM2_VALID)
		| (warn_two_r & ~alarm_warning_pkg::WRN2_VALID)) == '0)
		else $error("reserved bit read as one");
	chk_brake_check: assert property (drive_run_enable
		&& ((alarm_live_one & alarm_warning_pkg::ALM1_BRAKE_CHECK) != '0)
		|=> alarm_one_r[0])
		else $error("brake check not at lowest bit");
	chk_irq_set_wins: assert property (irq_set[alarm_warning_pkg::IRQ_WARN_BIT] && irq_sts_wr
		|=> irq_sts_r[alarm_warning_pkg::IRQ_WARN_BIT])
		else $error("event lost against clear");
	chk_read_data: assert property (apb_setup && !pwrite
		&& paddr == alarm_warning_pkg::OFS_ALARM_ONE ##1 psel && penable
		|-> prdata == $past(alarm_one_r) && !pslverr)
		else $error("alarm word read data wrong");

endmodule : alarm_warning_status_words

// file: verification/fieldbus_master_model.sv
// Fieldbus master model that reaches the drive status block over APB
module fieldbus_master_model (
	// Clock
	input wire logic pclk,
	// APB request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [alarm_warning_pkg::ADDR_W-1:0] paddr,
	output logic [alarm_warning_pkg::WORD_W-1:0] pwdata,
	output logic [3:0] pstrb,
	// APB answer
	input wire logic [alarm_warning_pkg::WORD_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Bus idle at time zero
	// ----------------------------------------------------------------
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
	end

	// One transfer: setup, access until pready, then release; bench timeout ends a hang
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // Released data no longer shows the last value
	endtask : xfer

	// Acknowledge: control bit three written low, then high
	task automatic ack();
		logic [31:0] q;
		logic e;
		xfer(1'b1, alarm_warning_pkg::OFS_CTRL, 32'h0000_0000, q, e);
		xfer(1'b1, alarm_warning_pkg::OFS_CTRL, 32'h0000_0008, q, e);
	endtask : ack
endmodule : fieldbus_master_model

// file: verification/alarm_warning_status_words_bench.sv
// Self-checking bench for the alarm and warning status words
module alarm_warning_status_words_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq;
	logic drive_run_enable, fault_active;
	logic [7:0] paddr;
	logic [3:0] pstrb;
	logic [31:0] pwdata, prdata;
	logic [31:0] ac1 = '0, ac2 = '0, wc1 = '0, wc2 = '0;
	logic [31:0] a1_tab [10];
	logic [31:0] a2_tab [10];
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	// Clock and timeout
	always #10 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			n_errors++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Design and master model
	// ----------------------------------------------------------------
	alarm_warning_status_words dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_cond_one(ac1),
		.alarm_cond_two(ac2), .warning_cond_one(wc1), .warning_cond_two(wc2),
		.drive_run_enable(drive_run_enable), .fault_active(fault_active), .irq(irq));
	fieldbus_master_model m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		m.xfer(1'b0, a, 32'h0000_0000, q, e);
		chk(name, exp, q);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		m.xfer(1'b1, a, d, q, e);
	endtask : wr

	// Conditions need three edges to reach the words; one spare
	task automatic cond(input logic [31:0] a1, a2, w1, w2);
		@(posedge pclk);
		ac1 <= a1;
		ac2 <= a2;
		wc1 <= w1;
		wc2 <= w2;
		repeat (4) @(posedge pclk);
	endtask : cond

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] q;
		logic e;
		a1_tab = '{32'h1, 32'h4, 32'h20, 32'h0008_0000, 32'h0010_0000, 32'h0020_0000,
			32'h0, 32'h0, 32'h0, 32'h5};
		a2_tab = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
			32'h1, 32'h0004_0000, 32'h0008_0000, 32'h0004_0000};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, unmapped address and read-only write
		for (int i = 0; i < 8; i++)
			rd("reset word", 8'(4 * i), 32'h0);
		chk("run after reset", 32'h1, {31'h0, drive_run_enable});
		chk("ready", 32'h1, {31'h0, pready});
		m.xfer(1'b0, 8'h20, 32'h0, q, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		wr(alarm_warning_pkg::OFS_ALARM_ONE, 32'hFFFF_FFFF);
		rd("alarm one ro", alarm_warning_pkg::OFS_ALARM_ONE, 32'h0);
		$display("test reset done");
		// Warnings, status toggle and interrupt mask
		cond(32'h0, 32'h0, 32'h8004_0000, 32'h0);
		rd("warning one", alarm_warning_pkg::OFS_WARN_ONE, 32'h0004_0000);
		rd("status toggle", alarm_warning_pkg::OFS_STATUS, 32'h80);
		chk("no fault on warning", 32'h0, {31'h0, fault_active});
		chk("irq masked", 32'h0, {31'h0, irq});
		cond(32'h0, 32'h0, 32'h8004_0000, 32'h8000_0007);
		rd("warning two", alarm_warning_pkg::OFS_WARN_TWO, 32'h7);
		rd("status toggle back", alarm_warning_pkg::OFS_STATUS, 32'h0);
		wr(alarm_warning_pkg::OFS_IRQ_MASK, 32'h2);
		@(posedge pclk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		cond(32'h0, 32'h0, 32'h0, 32'h0);
		rd("warning one clear", alarm_warning_pkg::OFS_WARN_ONE, 32'h0);
		rd("warning two clear", alarm_warning_pkg::OFS_WARN_TWO, 32'h0);
		rd("status toggle again", alarm_warning_pkg::OFS_STATUS, 32'h80);
		// Warning change reaches the word in the access cycle of the clear write
		wc1 <= 32'h0004_0000;
		wr(alarm_warning_pkg::OFS_IRQ_STS, 32'h2);
		rd("irq set wins", alarm_warning_pkg::OFS_IRQ_STS, 32'h2);
		cond(32'h0, 32'h0, 32'h0, 32'h0);
		wr(alarm_warning_pkg::OFS_IRQ_STS, 32'h2);
		rd("irq status clear", alarm_warning_pkg::OFS_IRQ_STS, 32'h0);
		chk("irq low", 32'h0, {31'h0, irq});
		rd("irq mask", alarm_warning_pkg::OFS_IRQ_MASK, 32'h2);
		wr(alarm_warning_pkg::OFS_IRQ_MASK, 32'h7);
		$display("test warnings done");
		// Every listed alarm, a combined one, early and proper acknowledge
		for (int i = 0; i < 10; i++)
		begin
			cond(a1_tab[i], a2_tab[i], 32'h0, 32'h0);
			chk("fault entered", 32'h1, {31'h0, fault_active});
			chk("run stopped", 32'h0, {31'h0, drive_run_enable});
			m.ack();
			repeat (2) @(posedge pclk);
			chk("ack with cause", 32'h1, {31'h0, fault_active});
			cond(32'h0, 32'h0, 32'h0, 32'h0);
			rd("alarm one", alarm_warning_pkg::OFS_ALARM_ONE, a1_tab[i]);
			rd("alarm two", alarm_warning_pkg::OFS_ALARM_TWO, a2_tab[i]);
			rd("status fault", alarm_warning_pkg::OFS_STATUS, 32'h88);
			m.ack();
			repeat (2) @(posedge pclk);
			chk("fault left", 32'h0, {31'h0, fault_active});
			chk("run again", 32'h1, {31'h0, drive_run_enable});
			rd("alarm one cleared", alarm_warning_pkg::OFS_ALARM_ONE, 32'h0);
			rd("alarm two cleared", alarm_warning_pkg::OFS_ALARM_TWO, 32'h0);
		end
		rd("control word", alarm_warning_pkg::OFS_CTRL, 32'h8);
		rd("irq events", alarm_warning_pkg::OFS_IRQ_STS, 32'h5);
		chk("irq on alarm", 32'h1, {31'h0, irq});
		wr(alarm_warning_pkg::OFS_IRQ_STS, 32'h5);
		@(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test alarms done");
		end_sim();
	end
endmodule : alarm_warning_status_words_bench
